// file: hdl/apit_defs.vh
// Constants for the periodic timer and watchdog block
`ifndef APIT_DEFS_VH
`define APIT_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_TIMER_CTRL 12'h000
`define OFS_TIMER_PERIOD 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_RC_TRIM 12'h010
`define OFS_WD_CTRL 12'h014
`define OFS_WD_SERVICE 12'h018
`define OFS_TIMER_COUNT 12'h01C
// ----------------------------------------
// Timer control fields
// ----------------------------------------
`define CTRL_ENABLE 0
`define CTRL_CLKSEL 1
`define CTRL_EXTACC 2
`define CTRL_FREEZE_STAT 3
// ----------------------------------------
// Status and mask fields
// ----------------------------------------
`define ST_TIMER_FLAG 0
`define ST_WD_RESET 1
// ----------------------------------------
// Watchdog control fields
// ----------------------------------------
`define WD_TIMEOUT_LSB 0
`define WD_TIMEOUT_MSB 2
`define WD_WINDOW_BIT 3
`define WD_LOCKED_BIT 4
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define PERIOD_RESET 16'h0000
`define TRIM_RESET 6'h20
`define WD_KEY_FIRST 8'h55
`define WD_KEY_SECOND 8'hAA
// ----------------------------------------
// Timing
// ----------------------------------------
`define STARTUP_DELAY_NS 100
`define CLK_PERIOD_NS 25
`define STARTUP_CYCLES 4'h4 // Delay rounded up to whole clock cycles
`define RC_DIV_MAX 6'h3F
`endif

// file: hdl/rc_tick_gen.v
// Tick generator standing in for the trimmable RC clock
`timescale 1ns/1ps
`include "apit_defs.vh"
module rc_tick_gen (
    input wire aclk,
    input wire aresetn,
    input wire [5:0] trim,
    output reg tick_q
);
    reg [5:0] cnt_q; // Divider count

    // --------------------------------
    // Divider: one pulse per trim+1 cycles
    // --------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (cnt_q >= trim) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 6'h01;
            tick_q <= 1'b0;
        end
    end
endmodule

// file: hdl/watchdog_unit.v
// Write-once watchdog with alternating service key check
`timescale 1ns/1ps
`include "apit_defs.vh"
module watchdog_unit (
    input wire aclk,
    input wire aresetn,
    input wire ctrl_we,
    input wire [3:0] ctrl_wdata,
    input wire svc_we,
    input wire [7:0] svc_wdata,
    output reg [2:0] timeout_sel_q,
    output reg window_en_q,
    output reg locked_q,
    output reg wd_reset_q
);
    reg expect_second_q; // Next key must be the second byte

    // --------------------------------
    // Configuration write-once and key sequence
    // --------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            timeout_sel_q <= 3'h0;
            window_en_q <= 1'b0;
            locked_q <= 1'b0;
            wd_reset_q <= 1'b0;
            expect_second_q <= 1'b0;
        end else begin
            wd_reset_q <= 1'b0;
            if (ctrl_we && !locked_q) begin
                timeout_sel_q <= ctrl_wdata[2:0];
                window_en_q <= ctrl_wdata[3];
                locked_q <= 1'b1;
            end
            if (svc_we && timeout_sel_q != 3'h0) begin
                if (svc_wdata == `WD_KEY_FIRST && !expect_second_q) begin
                    expect_second_q <= 1'b1;
                end else if (svc_wdata == `WD_KEY_SECOND && expect_second_q) begin
                    expect_second_q <= 1'b0;
                end else begin
                    // Bad or out-of-order byte
                    wd_reset_q <= 1'b1;
                    expect_second_q <= 1'b0;
                end
            end
        end
    end
endmodule

// file: hdl/periodic_wakeup_timer.v
// Periodic wakeup timer with AXI4-Lite registers and watchdog
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "apit_defs.vh"
module periodic_wakeup_timer (
    input wire aclk,
    input wire aresetn,
    input wire bus_clk_on,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg irq_q,
    output reg periodic_timer_wave_out,
    output reg watchdog_reset_q
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg periodic_timer_enable; // Timer run bit
    reg periodic_timer_clock_select; // 1 selects RC clock
    reg periodic_timer_external_access; // Pin drive enable
    reg [15:0] periodic_timer_period; // Period in ticks
    reg [5:0] rc_clock_trim; // RC tick divider
    reg [1:0] status_q; // Sticky event bits
    reg [1:0] mask_q; // Interrupt enables
    reg [15:0] count_q; // Ticks remaining
    reg wave_q; // Toggles each period
    reg [3:0] start_q; // Startup delay count
    // ----------------------------------------
    // Bus holding registers
    // ----------------------------------------
    reg [11:0] awaddr_q; // Captured write address
    reg aw_have_q; // Address held
    reg [31:0] wdata_q; // Captured write data
    reg [3:0] wstrb_q; // Captured strobes
    reg w_have_q; // Data held
    wire do_write; // Both halves present
    wire wr_ctrl; // Commit to timer control
    wire wr_period; // Commit to period
    wire wr_status; // Commit to status, write one clears
    wire wr_mask; // Commit to interrupt mask
    wire wr_trim; // Commit to RC trim
    wire wr_wdc; // Commit to watchdog control
    wire wr_wds; // Commit to watchdog service
    wire rc_tick; // Slow RC rate pulse
    wire step; // One count step
    wire period_done; // Period elapsed this cycle
    wire [2:0] wd_timeout; // Locked timeout select
    wire wd_window; // Locked window enable
    wire wd_locked; // Control write used up
    wire wd_rst; // Bad key pulse
    reg [31:0] rd_word; // Read mux result
    reg rd_ok; // Address mapped

    // Address match for a word-aligned register
    function hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr[11:2] == ofs[11:2]);
        end
    endfunction

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    // RC tick stands in for the slow trimmed oscillator
    // Watchdog sees only committed byte-lane-0 writes
    rc_tick_gen rc_tick_gen_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .trim(rc_clock_trim),
        .tick_q(rc_tick)
    );

    watchdog_unit watchdog_unit_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctrl_we(wr_wdc && wstrb_q[0]),
        .ctrl_wdata(wdata_q[3:0]),
        .svc_we(wr_wds && wstrb_q[0]),
        .svc_wdata(wdata_q[7:0]),
        .timeout_sel_q(wd_timeout),
        .window_en_q(wd_window),
        .locked_q(wd_locked),
        .wd_reset_q(wd_rst)
    );

    // Commit once both halves are held
    // and the previous response has been taken,
    // so a write never lands twice
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_ctrl = do_write && hit(awaddr_q, `OFS_TIMER_CTRL);
    assign wr_period = do_write && hit(awaddr_q, `OFS_TIMER_PERIOD);
    assign wr_status = do_write && hit(awaddr_q, `OFS_IRQ_STATUS);
    assign wr_mask = do_write && hit(awaddr_q, `OFS_IRQ_MASK);
    assign wr_trim = do_write && hit(awaddr_q, `OFS_RC_TRIM);
    assign wr_wdc = do_write && hit(awaddr_q, `OFS_WD_CTRL);
    assign wr_wds = do_write && hit(awaddr_q, `OFS_WD_SERVICE);

    // Clock source select, bus clock source frozen when bus clock gone, RC source keeps stepping
    assign step = periodic_timer_clock_select ? rc_tick : bus_clk_on;
    assign period_done = periodic_timer_enable && start_q == 4'h0 && step && count_q <= 16'h0001;

    // ----------------------------------------
    // Write channel capture
    // ----------------------------------------
    // Readies pulse every other idle cycle
    // Master must hold valid until it sees ready
    // Each half waits here until the other arrives
    // Response waits for the previous one to be taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped addresses answer SLVERR
                s_axi_bresp <= (awaddr_q <= (`OFS_TIMER_COUNT | 12'h003)) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Ignored writes still answer OKAY
    // Enable and pin access take effect at once
    // Trim and mask have no write guard
    always @(posedge aclk) begin
        if (!aresetn) begin
            periodic_timer_enable <= 1'b0;
            periodic_timer_clock_select <= 1'b0;
            periodic_timer_external_access <= 1'b0;
            periodic_timer_period <= `PERIOD_RESET;
            rc_clock_trim <= `TRIM_RESET;
            mask_q <= 2'b00;
        end else begin
            if (wr_ctrl && wstrb_q[0]) begin
                periodic_timer_enable <= wdata_q[`CTRL_ENABLE];
                periodic_timer_external_access <= wdata_q[`CTRL_EXTACC];
                // Select only changes while disabled
                if (!periodic_timer_enable) begin
                    periodic_timer_clock_select <= wdata_q[`CTRL_CLKSEL];
                end
            end
            // Period only changes while disabled
            if (wr_period && !periodic_timer_enable) begin
                if (wstrb_q[0]) periodic_timer_period[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) periodic_timer_period[15:8] <= wdata_q[15:8];
            end
            if (wr_trim && wstrb_q[0]) begin
                rc_clock_trim <= wdata_q[5:0];
            end
            if (wr_mask && wstrb_q[0]) begin
                mask_q <= wdata_q[1:0];
            end
        end
    end

    // ----------------------------------------
    // Period counter
    // ----------------------------------------
    // Disabled: count preloaded so enabling starts a period
    // Startup delay eats into the first period only
    // Reload on the elapsing step, no lost cycle
    // No step while the selected clock is stopped
    // Period zero behaves as one
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 16'h0000;
            start_q <= 4'h0;
            wave_q <= 1'b0;
        end else if (!periodic_timer_enable) begin
            // Idle: arm startup delay and load period
            start_q <= `STARTUP_CYCLES;
            count_q <= periodic_timer_period;
            wave_q <= 1'b0;
        end else if (start_q != 4'h0) begin
            // Startup delay overlaps the first period
            start_q <= start_q - 4'h1;
            if (step && count_q > 16'h0001) count_q <= count_q - 16'h0001;
        end else if (period_done) begin
            count_q <= periodic_timer_period;
            wave_q <= !wave_q;
        end else if (step) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // ----------------------------------------
    // Sticky status, set wins over clear
    // ----------------------------------------
    // Event in the same cycle as a clear keeps the bit
    // Only byte lane 0 clears
    // Flag stays while the timer is disabled
    always @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= 2'b00;
        end else begin
            status_q[`ST_TIMER_FLAG] <= period_done ||
                (status_q[`ST_TIMER_FLAG] &&
                 !(wr_status && wstrb_q[0] && wdata_q[`ST_TIMER_FLAG]));
            status_q[`ST_WD_RESET] <= wd_rst ||
                (status_q[`ST_WD_RESET] &&
                 !(wr_status && wstrb_q[0] && wdata_q[`ST_WD_RESET]));
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // One cycle behind status and mask
    // Pin low whenever either enable is off
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
            periodic_timer_wave_out <= 1'b0;
            watchdog_reset_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
            periodic_timer_wave_out <= periodic_timer_enable &&
                periodic_timer_external_access && wave_q;
            watchdog_reset_q <= wd_rst;
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // Decoded on the offered address
    // Unmapped offsets read zero with an error
    always @* begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (hit(s_axi_araddr, `OFS_TIMER_CTRL)) begin
            rd_word[`CTRL_ENABLE] = periodic_timer_enable;
            rd_word[`CTRL_CLKSEL] = periodic_timer_clock_select;
            rd_word[`CTRL_EXTACC] = periodic_timer_external_access;
            rd_word[`CTRL_FREEZE_STAT] = !periodic_timer_clock_select && !bus_clk_on;
        end else if (hit(s_axi_araddr, `OFS_TIMER_PERIOD)) begin
            rd_word[15:0] = periodic_timer_period;
        end else if (hit(s_axi_araddr, `OFS_IRQ_STATUS)) begin
            rd_word[1:0] = status_q;
        end else if (hit(s_axi_araddr, `OFS_IRQ_MASK)) begin
            rd_word[1:0] = mask_q;
        end else if (hit(s_axi_araddr, `OFS_RC_TRIM)) begin
            rd_word[5:0] = rc_clock_trim;
        end else if (hit(s_axi_araddr, `OFS_WD_CTRL)) begin
            rd_word[2:0] = wd_timeout;
            rd_word[`WD_WINDOW_BIT] = wd_window;
            rd_word[`WD_LOCKED_BIT] = wd_locked;
        end else if (hit(s_axi_araddr, `OFS_WD_SERVICE)) begin
            rd_word = 32'h0000_0000;
        end else if (hit(s_axi_araddr, `OFS_TIMER_COUNT)) begin
            rd_word[15:0] = count_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    // Data latched as the address is taken
    // No new address while a read is pending
    // Ready pulses every other idle cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: bench/periodic_wakeup_timer_properties.sv
// Port checks for the periodic wakeup timer
`timescale 1ns/1ps
module periodic_wakeup_timer_properties (
    input logic aclk,
    input logic aresetn,
    input logic bus_clk_on,
    input logic [11:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [11:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic irq_q,
    input logic periodic_timer_wave_out,
    input logic watchdog_reset_q
);
// ----
// Shadow of committed writes
// ----
logic [11:0] wa_q; // Write address
logic [31:0] wd_q; // Write data
logic [2:0] ctl_q; // Enable, clock select, pin access
logic [1:0] mask_q; // Interrupt mask
logic [1:0] off_q; // Bus clock off cycles, saturating
logic wave_on; // Shadow allows the pin to move
assign wave_on = ctl_q[0] && ctl_q[2];

// Follows settings as their write responses are taken
always @(posedge aclk) begin
    if (!aresetn) begin
        wa_q <= 12'h000;
        wd_q <= 32'h0;
        ctl_q <= 3'h0;
        mask_q <= 2'h0;
        off_q <= 2'h0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            wa_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd_q <= s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready && wa_q == 12'h000) begin
            ctl_q[0] <= wd_q[0];
            ctl_q[2] <= wd_q[2];
            // Clock select moves only while stopped
            if (!ctl_q[0]) begin
                ctl_q[1] <= wd_q[1];
            end
        end
        if (s_axi_bvalid && s_axi_bready && wa_q == 12'h00C) begin
            mask_q <= wd_q[1:0];
        end
        if (bus_clk_on) begin
            off_q <= 2'h0;
        end else if (off_q != 2'h3) begin
            off_q <= off_q + 2'h1;
        end
    end
end

// ----
// Assertions
// ----
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);

chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
chk_bad_addr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr > 12'h01C |-> ##[1:2] (s_axi_bvalid
    && s_axi_bresp == 2'b10)) else $error("unmapped write not refused");
chk_read_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 12'h01C
    |=> s_axi_rvalid && s_axi_rresp == 2'b00) else $error("mapped read not answered");
chk_wd_pulse: assert property (
    watchdog_reset_q |=> !watchdog_reset_q) else $error("watchdog reset not a pulse");
chk_wave_quiet: assert property (
    !wave_on && !$past(wave_on, 2)
    |-> $stable(periodic_timer_wave_out)) else $error("wave moved while off");
chk_irq_masked: assert property (
    mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq_q) else $error("masked irq seen");
chk_freeze_hold: assert property (
    ctl_q[0] && !ctl_q[1] && off_q == 2'h3 |-> $stable(periodic_timer_wave_out))
    else $error("timer ran with bus clock off");
endmodule

bind periodic_wakeup_timer periodic_wakeup_timer_properties periodic_wakeup_timer_properties_i (
    .aclk(aclk), .aresetn(aresetn), .bus_clk_on(bus_clk_on),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_q(irq_q),
    .periodic_timer_wave_out(periodic_timer_wave_out), .watchdog_reset_q(watchdog_reset_q));

// file: bench/testbench.sv
// Self-checking bench for the periodic wakeup timer
`timescale 1ns/1ps
module testbench;
// ----
// Signals
// ----
logic aclk = 1'b0, aresetn = 1'b0, bus_clk_on = 1'b1;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
logic [31:0] s_axi_wdata = 32'h0;
logic [3:0] s_axi_wstrb = 4'h0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [31:0] s_axi_rdata;
logic irq_q, periodic_timer_wave_out, watchdog_reset_q;
int num_errors = 0, cmp_count = 0, pulses = 0, n, per;
logic [31:0] exp_q[$], msk_q[$], bexp_q[$]; // Pending expectations

periodic_wakeup_timer periodic_wakeup_timer_i (
    .aclk(aclk), .aresetn(aresetn), .bus_clk_on(bus_clk_on),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_q(irq_q),
    .periodic_timer_wave_out(periodic_timer_wave_out), .watchdog_reset_q(watchdog_reset_q));

// 40 MHz clock
always #12.5 aclk = ~aclk;

// ----
// Tasks
// ----
task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
        num_errors++;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
endtask

task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask

// Write with both channels offered together
task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    bexp_q.push_back({30'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
        @(posedge aclk);
        t++;
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 100);
    if (s_axi_bvalid !== 1'b1) num_errors++; // Response never came
    s_axi_bready <= 1'b0;
endtask

// Read; the monitor compares the masked data
task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    int t;
    t = 0;
    @(posedge aclk);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
        @(posedge aclk);
        t++;
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 100);
    if (s_axi_rvalid !== 1'b1) num_errors++; // Read data never came
    s_axi_rready <= 1'b0;
endtask

// Cycles until the pin changes, capped at 3000
task automatic wait_toggle(output int c);
    logic w;
    w = periodic_timer_wave_out;
    c = 0;
    do begin
        @(posedge aclk);
        c++;
    end while (periodic_timer_wave_out === w && c < 3000);
endtask

// One full period, optionally with the bus clock off for a while
task automatic period_chk(input int e, input int hold);
    wait_toggle(n);
    if (hold > 0) begin
        bus_clk_on <= 1'b0;
        repeat (hold) @(posedge aclk);
        bus_clk_on <= 1'b1;
    end
    wait_toggle(n);
    check(32'(n), 32'(e));
endtask

// Pin must stay put
task automatic quiet_chk;
    repeat (3) @(posedge aclk);
    wait_toggle(n);
    check(32'(n), 32'd3000);
endtask

// Response monitor and pulse counter
always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check({30'h0, s_axi_bresp}, bexp_q.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check(s_axi_rdata & msk_q.pop_front(), exp_q.pop_front());
    if (watchdog_reset_q === 1'b1) pulses++;
end

// Hang guard
initial begin
    #(25 * 30000);
    num_errors++;
    results;
end

// ----
// Main sequence
// ----
initial begin
    n = $urandom(32'hc766);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, 32'h0, 32'h7);
    rd(12'h004, 32'h0, 32'hffff);
    rd(12'h010, 32'h20, 32'h3f);
    rd(12'h00C, 32'h0, 32'h3);
    wr(12'h040, 32'h1, 2'b10);
    $display("test reset_values done");
    per = $urandom_range(40, 8);
    wr(12'h004, 32'(per), 2'b00);
    wr(12'h000, 32'h5, 2'b00);
    period_chk(per, 0);
    wr(12'h004, 32'(per + 5), 2'b00);
    wr(12'h000, 32'h7, 2'b00);
    rd(12'h004, 32'(per), 32'hffff);
    rd(12'h000, 32'h5, 32'h7);
    period_chk(per, 0);
    period_chk(per, 9);
    wr(12'h000, 32'h1, 2'b00);
    quiet_chk;
    wr(12'h000, 32'h4, 2'b00);
    quiet_chk;
    bus_clk_on <= 1'b0;
    rd(12'h000, 32'hc, 32'hf);
    rd(12'h01C, 32'(per), 32'hffff);
    bus_clk_on <= 1'b1;
    $display("test bus_clock done");
    per = $urandom_range(20, 4);
    wr(12'h010, 32'h3, 2'b00);
    wr(12'h004, 32'(per), 2'b00);
    wr(12'h000, 32'h6, 2'b00);
    wr(12'h000, 32'h7, 2'b00);
    rd(12'h000, 32'h7, 32'h7);
    period_chk(4 * per, 0);
    period_chk(4 * per - 9, 9);
    $display("test rc_clock done");
    rd(12'h008, 32'h1, 32'h1);
    check(32'(irq_q), 32'h0);
    wr(12'h00C, 32'h1, 2'b00);
    repeat (2) @(posedge aclk);
    check(32'(irq_q), 32'h1);
    wr(12'h000, 32'h0, 2'b00);
    wr(12'h008, 32'h0, 2'b00);
    rd(12'h008, 32'h1, 32'h1);
    wr(12'h008, 32'h1, 2'b00);
    rd(12'h008, 32'h0, 32'h1);
    check(32'(irq_q), 32'h0);
    $display("test interrupt done");
    wr(12'h014, 32'h3, 2'b00);
    wr(12'h014, 32'hc, 2'b00);
    rd(12'h014, 32'h13, 32'h1f);
    wr(12'h018, 32'h55, 2'b00);
    wr(12'h018, 32'haa, 2'b00);
    wr(12'h018, 32'haa, 2'b00);
    repeat (3) @(posedge aclk);
    check(32'(pulses), 32'h1);
    wr(12'h018, 32'($urandom_range(84, 0)), 2'b00);
    repeat (3) @(posedge aclk);
    check(32'(pulses), 32'h2);
    rd(12'h008, 32'h2, 32'h2);
    $display("test watchdog done");
    results;
end
endmodule
